// File: hw/light_sensor_pkg.sv
package light_sensor_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_LIGHT_CONFIG        = 8'h90;
    localparam logic [7:0] ADDR_STATUS              = 8'h93;
    localparam logic [7:0] ADDR_VISIBLE_RESULT_HIGH = 8'h95;
    localparam logic [7:0] ADDR_INFRARED_RESULT_LOW = 8'h96;
    localparam logic [7:0] ADDR_INFRARED_RESULT_HIGH = 8'h97;
    localparam logic [7:0] ADDR_PROXIMITY_RESULT    = 8'h9c;
    localparam logic [7:0] ADDR_PACKAGE_ID          = 8'h9e;
    localparam logic [7:0] ADDR_GAIN_EXT_CONFIG     = 8'h9f;
    localparam logic [7:0] ADDR_IRQ_SLEEP_CONFIG    = 8'hab;
    localparam logic [7:0] ADDR_PROX_OFFSET_MAG     = 8'hc0;
    localparam logic [7:0] ADDR_PROX_OFFSET_SIGN    = 8'hc1;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_MAX_GAIN         = 4;
    localparam int BIT_LOW_GAIN_DISABLE = 2;
    localparam int BIT_INT_READ_CLEAR   = 7;
    localparam int BIT_SLEEP_AFTER_IRQ  = 4;
    localparam int BIT_LIGHT_IRQ_FLAG   = 4;
    localparam int BIT_PROX_IRQ_FLAG    = 5;
    localparam int BIT_OFFSET_SIGN      = 0;

    // ****************************************************************
    // Reset values and identity
    // ****************************************************************
    localparam logic [7:0] RST_LIGHT_CONFIG  = 8'h00;
    localparam logic [7:0] RST_GAIN_EXT      = 8'h04;
    localparam logic [7:0] RST_IRQ_SLEEP     = 8'h4c;
    localparam logic [7:0] RST_ZERO          = 8'h00;
    // Arbitrary neutral value
    localparam logic [3:0] PACKAGE_ID_VALUE  = 4'h5;
    localparam logic [3:0] PACKAGE_ID_UPPER  = 4'h0;

    // ****************************************************************
    // Overall gain codes: log2(gain) + 1
    // ****************************************************************
    localparam logic [3:0] GAIN_HALF = 4'h0;
    localparam logic [3:0] GAIN_X128 = 4'h8;
    localparam logic [1:0] BASE_GAIN_TOP = 2'h3;

    // ****************************************************************
    // Sleep control states and block state
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_AWAKE  = 2'b01,
        ST_ASLEEP = 2'b10
    } sleep_state_e;

    typedef struct packed {
        logic [7:0]   light_config;
        logic [7:0]   status;
        logic [7:0]   visible_result_high;
        logic [7:0]   infrared_result_low;
        logic [7:0]   infrared_result_high;
        logic [7:0]   proximity_result;
        logic [7:0]   gain_extension_config;
        logic [7:0]   interrupt_sleep_config;
        logic [7:0]   proximity_offset_magnitude;
        logic [7:0]   proximity_offset_sign;
        logic [7:0]   rdata;
        sleep_state_e sleep_st;
    } regs_s;

    localparam regs_s REGS_RESET = '{
        light_config:               RST_LIGHT_CONFIG,
        status:                     RST_ZERO,
        visible_result_high:        RST_ZERO,
        infrared_result_low:        RST_ZERO,
        infrared_result_high:       RST_ZERO,
        proximity_result:           RST_ZERO,
        gain_extension_config:      RST_GAIN_EXT,
        interrupt_sleep_config:     RST_IRQ_SLEEP,
        proximity_offset_magnitude: RST_ZERO,
        proximity_offset_sign:      RST_ZERO,
        rdata:                      RST_ZERO,
        sleep_st:                   ST_AWAKE
    };

    localparam logic [8:0] PROX_MAX = 9'h0ff;

endpackage

// File: hw/light_sensor_result_config_regs.sv
`timescale 1ns/1ps
// Behaviour
// - visible high byte, read-only, resets zero
// - infrared low and high bytes, read-only
// - proximity result byte, read-only, resets zero
// - package code low nibble, upper zero
// - max-gain bit4 reset0, low-gain-disable bit2 reset1
// - overall gain from base field and extensions
// - status read clears flags when enabled
// - oscillator gated by power-on and sleep
// - enabled interrupt at cycle end sleeps
// - asleep looks powered off, power-on unchanged
// - clearing interrupt flags restarts the oscillator
// - offset magnitude byte, read-write, resets zero
// - signed offset applied to proximity result
// - offset sign in bit0, resets zero
// - writing one clears that status flag
// - base gain field bits 1:0, reset 00
module light_sensor_result_config_regs
    import light_sensor_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // Byte register access from the serial front end
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // Measurement engines
    input  wire logic        i_als_done,
    input  wire logic [15:0] i_vis_result,
    input  wire logic [15:0] i_ir_result,
    input  wire logic        i_prox_done,
    input  wire logic [7:0]  i_prox_raw,
    input  wire logic [7:0]  i_flag_set,
    // Controls held elsewhere
    input  wire logic        i_power_on_bit,
    input  wire logic        i_light_irq_enable,
    input  wire logic        i_proximity_irq_enable,
    // Status toward the analogue side
    output logic             o_osc_run,
    output logic             o_int_n,
    output logic      [3:0]  o_gain_code,
    output logic      [7:0]  o_prox_adjusted
);

    // ****************************************************************
    // Gain decode
    // ****************************************************************
    function automatic logic [3:0] gain_decode(input logic [1:0] base,
                                               input logic       max_gain_bit,
                                               input logic       low_gain_disable_bit);
        logic [3:0] code;
        code = {1'b0, base, 1'b1};
        if (max_gain_bit && base == BASE_GAIN_TOP && low_gain_disable_bit) begin
            code = GAIN_X128;
        end else if (!low_gain_disable_bit) begin
            code = code - 4'h1;
        end
        return code;
    endfunction

    function automatic logic irq_active(input logic [7:0] flags,
                                        input logic       light_en,
                                        input logic       prox_en);
        return (flags[BIT_LIGHT_IRQ_FLAG] & light_en) |
               (flags[BIT_PROX_IRQ_FLAG] & prox_en);
    endfunction

    regs_s       q;
    regs_s       d;
    logic        wr_hit;
    logic        rd_status;
    logic        read_clear;
    logic        sleep_after_irq;
    logic        cycle_end;
    logic        asleep;
    logic [7:0]  status_clr;
    logic [7:0]  prox_adj;

    // ****************************************************************
    // Proximity offset
    // ****************************************************************
    prox_offset_apply u_offset (
        .i_raw       (i_prox_raw),
        .i_magnitude (q.proximity_offset_magnitude),
        .i_negative  (q.proximity_offset_sign[BIT_OFFSET_SIGN]),
        .o_adjusted  (prox_adj)
    );

    // ****************************************************************
    // Oscillator and interrupt pin
    // ****************************************************************
    assign sleep_after_irq = q.interrupt_sleep_config[BIT_SLEEP_AFTER_IRQ];
    assign asleep          = (q.sleep_st == ST_ASLEEP);
    // Power-on readback is untouched; only the run gate drops
    assign o_osc_run   = i_power_on_bit & ~(sleep_after_irq & asleep);
    assign o_int_n     = ~irq_active(q.status, i_light_irq_enable, i_proximity_irq_enable);
    assign o_gain_code = gain_decode(q.light_config[1:0],
                                     q.gain_extension_config[BIT_MAX_GAIN],
                                     q.gain_extension_config[BIT_LOW_GAIN_DISABLE]);
    assign o_reg_rdata     = q.rdata;
    assign o_prox_adjusted = q.proximity_result;
    // Engine strobes while stopped are stale, so they are dropped
    assign cycle_end = (i_als_done | i_prox_done) & o_osc_run;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d          = q;
        wr_hit     = i_reg_wr;
        rd_status  = i_reg_rd && i_reg_addr == ADDR_STATUS;
        read_clear = rd_status && q.interrupt_sleep_config[BIT_INT_READ_CLEAR];
        status_clr = 8'h00;

        // Results from the engines; no write path reaches them
        if (i_als_done && o_osc_run) begin
            d.visible_result_high  = i_vis_result[15:8];
            d.infrared_result_low  = i_ir_result[7:0];
            d.infrared_result_high = i_ir_result[15:8];
        end
        if (i_prox_done && o_osc_run) begin
            d.proximity_result = prox_adj;
        end

        // Writable registers; read-only offsets fall through untouched
        if (wr_hit) begin
            case (i_reg_addr)
                ADDR_LIGHT_CONFIG:     d.light_config = i_reg_wdata;
                ADDR_STATUS:           status_clr = i_reg_wdata;
                ADDR_GAIN_EXT_CONFIG:  d.gain_extension_config = i_reg_wdata;
                ADDR_IRQ_SLEEP_CONFIG: d.interrupt_sleep_config = i_reg_wdata;
                ADDR_PROX_OFFSET_MAG:  d.proximity_offset_magnitude = i_reg_wdata;
                ADDR_PROX_OFFSET_SIGN: d.proximity_offset_sign = i_reg_wdata;
                default: begin
                    d.light_config = q.light_config;
                end
            endcase
        end

        if (read_clear) begin
            status_clr = 8'hff;
        end
        // A flag raised in the clearing cycle survives
        d.status = (q.status & ~status_clr) | i_flag_set;

        // Read data captured with the pre-clear status
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_LIGHT_CONFIG:         d.rdata = q.light_config;
                ADDR_STATUS:               d.rdata = q.status;
                ADDR_VISIBLE_RESULT_HIGH:  d.rdata = q.visible_result_high;
                ADDR_INFRARED_RESULT_LOW:  d.rdata = q.infrared_result_low;
                ADDR_INFRARED_RESULT_HIGH: d.rdata = q.infrared_result_high;
                ADDR_PROXIMITY_RESULT:     d.rdata = q.proximity_result;
                ADDR_PACKAGE_ID:           d.rdata = {PACKAGE_ID_UPPER, PACKAGE_ID_VALUE};
                ADDR_GAIN_EXT_CONFIG:      d.rdata = q.gain_extension_config;
                ADDR_IRQ_SLEEP_CONFIG:     d.rdata = q.interrupt_sleep_config;
                ADDR_PROX_OFFSET_MAG:      d.rdata = q.proximity_offset_magnitude;
                ADDR_PROX_OFFSET_SIGN:     d.rdata = q.proximity_offset_sign;
                default:                   d.rdata = RST_ZERO;
            endcase
        end

        // Sleep control
        case (q.sleep_st)
            ST_AWAKE: begin
                if (cycle_end && sleep_after_irq &&
                    irq_active(d.status, i_light_irq_enable, i_proximity_irq_enable)) begin
                    d.sleep_st = ST_ASLEEP;
                end
            end
            ST_ASLEEP: begin
                // The host clearing the flags or dropping the sleep bit wakes the part
                if (!q.status[BIT_LIGHT_IRQ_FLAG] && !q.status[BIT_PROX_IRQ_FLAG]) begin
                    d.sleep_st = ST_AWAKE;
                end else if (!sleep_after_irq) begin
                    d.sleep_st = ST_AWAKE;
                end
            end
            default: begin
                d.sleep_st = ST_AWAKE;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    property p_visible_capture;
        (i_als_done && o_osc_run) |=> q.visible_result_high == $past(i_vis_result[15:8]);
    endproperty
    a_visible_capture: assert property (p_visible_capture)
        else $error("visible high byte not captured");

    property p_infrared_capture;
        (i_als_done && o_osc_run) |=>
            {q.infrared_result_high, q.infrared_result_low} == $past(i_ir_result);
    endproperty
    a_infrared_capture: assert property (p_infrared_capture)
        else $error("infrared bytes not captured");

    property p_readonly_hold;
        (i_reg_wr && i_reg_addr == ADDR_PROXIMITY_RESULT && !i_prox_done)
            |=> $stable(q.proximity_result);
    endproperty
    a_readonly_hold: assert property (p_readonly_hold)
        else $error("write changed a read-only result");

    property p_package_read;
        (i_reg_rd && i_reg_addr == ADDR_PACKAGE_ID)
            |=> o_reg_rdata == {PACKAGE_ID_UPPER, PACKAGE_ID_VALUE};
    endproperty
    a_package_read: assert property (p_package_read)
        else $error("package code readback wrong");

    property p_gain_top;
        (q.light_config[1:0] == BASE_GAIN_TOP && q.gain_extension_config[BIT_MAX_GAIN]
         && q.gain_extension_config[BIT_LOW_GAIN_DISABLE]) |-> o_gain_code == GAIN_X128;
    endproperty
    a_gain_top: assert property (p_gain_top)
        else $error("top gain not selected");

    property p_read_clear;
        (rd_status && q.interrupt_sleep_config[BIT_INT_READ_CLEAR] && i_flag_set == RST_ZERO)
            |=> q.status == RST_ZERO ##1 (q.sleep_st == ST_AWAKE || $past(cycle_end));
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status not cleared by read");

    property p_osc_off;
        !i_power_on_bit |-> !o_osc_run;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator runs without power-on");

    property p_sleep_entry;
        (cycle_end && sleep_after_irq && q.sleep_st == ST_AWAKE &&
         irq_active(d.status, i_light_irq_enable, i_proximity_irq_enable) &&
         !(i_reg_wr && i_reg_addr == ADDR_IRQ_SLEEP_CONFIG)) |=> !o_osc_run;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("oscillator kept running after interrupt");

    property p_write_one_clear;
        (i_reg_wr && i_reg_addr == ADDR_STATUS && i_flag_set == RST_ZERO)
            |=> (q.status & $past(i_reg_wdata)) == RST_ZERO;
    endproperty
    a_write_one_clear: assert property (p_write_one_clear)
        else $error("status not cleared by write");

    property p_wake;
        (asleep && i_power_on_bit && !q.status[BIT_LIGHT_IRQ_FLAG] &&
         !q.status[BIT_PROX_IRQ_FLAG]) |=> o_osc_run || !i_power_on_bit;
    endproperty
    a_wake: assert property (p_wake)
        else $error("oscillator did not restart");

    property p_gain_half;
        (~|q.light_config[1:0] && !q.gain_extension_config[BIT_LOW_GAIN_DISABLE])
            |-> o_gain_code == GAIN_HALF;
    endproperty
    a_gain_half: assert property (p_gain_half)
        else $error("half gain not selected");

    property p_prox_capture;
        (i_prox_done && o_osc_run) |=> q.proximity_result == $past(prox_adj);
    endproperty
    a_prox_capture: assert property (p_prox_capture)
        else $error("proximity result not captured");

    // Stopped part must ignore engine strobes entirely
    property p_stopped_hold;
        !o_osc_run |=> $stable(q.visible_result_high) && $stable(q.proximity_result);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold)
        else $error("result changed while stopped");

    property p_magnitude_write;
        (i_reg_wr && i_reg_addr == ADDR_PROX_OFFSET_MAG)
            |=> q.proximity_offset_magnitude == $past(i_reg_wdata);
    endproperty
    a_magnitude_write: assert property (p_magnitude_write)
        else $error("offset magnitude not written");

    property p_sign_write;
        (i_reg_wr && i_reg_addr == ADDR_PROX_OFFSET_SIGN)
            |=> q.proximity_offset_sign[BIT_OFFSET_SIGN] == $past(i_reg_wdata[BIT_OFFSET_SIGN]);
    endproperty
    a_sign_write: assert property (p_sign_write)
        else $error("offset sign not written");

endmodule

// File: hw/prox_offset_apply.sv
`timescale 1ns/1ps
module prox_offset_apply
    import light_sensor_pkg::*;
(
    // Raw measurement and offset
    input  wire logic [7:0] i_raw,
    input  wire logic [7:0] i_magnitude,
    input  wire logic       i_negative,
    // Adjusted measurement
    output logic      [7:0] o_adjusted
);

    logic [8:0] sum;

    // ****************************************************************
    // Signed offset, clamped to the result range
    // ****************************************************************
    // Saturate rather than wrap so a large offset never flips near to far
    always_comb begin
        sum = 9'h000;
        if (i_negative) begin
            if (i_magnitude > i_raw) begin
                o_adjusted = 8'h00;
            end else begin
                o_adjusted = i_raw - i_magnitude;
            end
        end else begin
            sum = {1'b0, i_raw} + {1'b0, i_magnitude};
            o_adjusted = (sum > PROX_MAX) ? PROX_MAX[7:0] : sum[7:0];
        end
    end

endmodule

// File: tb/light_sensor_result_config_regs_test.sv
`timescale 1ns/1ps
module light_sensor_result_config_regs_test
    import light_sensor_pkg::*;
;
    // ****************************************************************
    // Signals and tables
    // ****************************************************************
    typedef struct { logic [7:0] addr; logic [7:0] exp; } row_s;
    typedef struct { logic [7:0] cfg; logic [7:0] ext; logic [3:0] code; } gain_s;
    typedef struct { logic [7:0] mag; logic [7:0] sgn; logic [7:0] raw; logic [7:0] exp; } offs_s;
    logic        i_ref_clk, i_nrst, i_reg_wr, i_reg_rd, i_als_done, i_prox_done;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_prox_raw, i_flag_set;
    logic [15:0] i_vis_result, i_ir_result;
    logic        i_power_on_bit, i_light_irq_enable, i_proximity_irq_enable;
    logic        o_osc_run, o_int_n;
    logic [3:0]  o_gain_code;
    logic [7:0]  o_prox_adjusted, rd_v;
    int          error_cnt, n_tests, i;
    // First five rows are read-only
    row_s  rows [12] = '{'{8'h95, 8'h00}, '{8'h96, 8'h00}, '{8'h97, 8'h00}, '{8'h9c, 8'h00},
                         '{8'h9e, {PACKAGE_ID_UPPER, PACKAGE_ID_VALUE}}, '{8'h9f, 8'h04},
                         '{8'hab, 8'h4c}, '{8'hc0, 8'h00}, '{8'hc1, 8'h00}, '{8'h90, 8'h00},
                         '{8'h93, 8'h00}, '{8'h50, 8'h00}};
    // Last row: max bit alone must not lift a lower base
    gain_s gains [7] = '{'{8'h00, 8'h00, 4'h0}, '{8'h00, 8'h04, 4'h1}, '{8'h01, 8'h04, 4'h3},
                         '{8'h02, 8'h04, 4'h5}, '{8'h03, 8'h04, 4'h7}, '{8'h03, 8'h14, 4'h8},
                         '{8'h01, 8'h14, 4'h3}};
    offs_s offs [4]  = '{'{8'h03, 8'h01, 8'h0a, 8'h07}, '{8'h20, 8'h00, 8'hf0, 8'hff},
                         '{8'h20, 8'h01, 8'h10, 8'h00}, '{8'hff, 8'h00, 8'h00, 8'hff}};

    reg_host_model u_reg_host_model (
        .i_ref_clk  (i_ref_clk), .o_reg_addr (i_reg_addr), .o_reg_wdata(i_reg_wdata),
        .o_reg_wr   (i_reg_wr),  .o_reg_rd   (i_reg_rd),   .i_reg_rdata(o_reg_rdata));
    light_sensor_result_config_regs u_light_sensor_result_config_regs (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_als_done(i_als_done), .i_vis_result(i_vis_result),
        .i_ir_result(i_ir_result), .i_prox_done(i_prox_done), .i_prox_raw(i_prox_raw),
        .i_flag_set(i_flag_set), .i_power_on_bit(i_power_on_bit),
        .i_light_irq_enable(i_light_irq_enable),
        .i_proximity_irq_enable(i_proximity_irq_enable), .o_osc_run(o_osc_run),
        .o_int_n(o_int_n), .o_gain_code(o_gain_code), .o_prox_adjusted(o_prox_adjusted));

    always #10 i_ref_clk = ~i_ref_clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic report(input logic bad, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (bad) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        report(got !== exp, got, exp);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        report(got !== exp, {7'h00, got}, {7'h00, exp});
    endtask
    task automatic chk_code(input logic [3:0] got, input logic [3:0] exp);
        report(got !== exp, {4'h0, got}, {4'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_reg_host_model.reg_write(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_reg_host_model.reg_read(a, rd_v);
        chk_byte(rd_v, exp);
    endtask
    task automatic set_data(input logic [15:0] vis, input logic [15:0] ir, input logic [7:0] raw);
        @(posedge i_ref_clk);
        i_vis_result <= vis;
        i_ir_result  <= ir;
        i_prox_raw   <= raw;
    endtask
    task automatic pulse(input logic als, input logic prox, input logic [7:0] fl);
        @(posedge i_ref_clk);
        i_als_done  <= als;
        i_prox_done <= prox;
        i_flag_set  <= fl;
        @(posedge i_ref_clk);
        i_als_done  <= 1'b0;
        i_prox_done <= 1'b0;
        i_flag_set  <= 8'h00;
        #1;
    endtask
    task automatic do_reset;
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        #1;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        {i_ref_clk, i_nrst, i_als_done, i_prox_done} = 4'h0;
        {i_vis_result, i_ir_result, i_prox_raw, i_flag_set} = 48'h0;
        {i_light_irq_enable, i_proximity_irq_enable} = 2'b00;
        i_power_on_bit = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        do_reset();
        foreach (rows[k]) rd_chk(rows[k].addr, rows[k].exp);
        for (i = 0; i < 5; i++) wr(rows[i].addr, 8'hff);
        for (i = 0; i < 5; i++) rd_chk(rows[i].addr, rows[i].exp);
        foreach (gains[k]) begin
            wr(8'h90, gains[k].cfg);
            wr(8'h9f, gains[k].ext);
            chk_code(o_gain_code, gains[k].code);
            rd_chk(8'h9f, gains[k].ext);
        end
        set_data(16'ha55a, 16'h1234, 8'h00);
        pulse(1'b1, 1'b0, 8'h00);
        rd_chk(8'h95, 8'ha5);
        rd_chk(8'h96, 8'h34);
        rd_chk(8'h97, 8'h12);
        foreach (offs[k]) begin
            wr(8'hc0, offs[k].mag);
            wr(8'hc1, offs[k].sgn);
            set_data(16'ha55a, 16'h1234, offs[k].raw);
            pulse(1'b0, 1'b1, 8'h00);
            chk_byte(o_prox_adjusted, offs[k].exp);
            rd_chk(8'h9c, offs[k].exp);
            rd_chk(8'hc0, offs[k].mag);
            rd_chk(8'hc1, offs[k].sgn);
        end
        @(posedge i_ref_clk);
        i_light_irq_enable     <= 1'b1;
        i_proximity_irq_enable <= 1'b1;
        pulse(1'b0, 1'b0, 8'h10);
        chk_bit(o_int_n, 1'b0);
        rd_chk(8'h93, 8'h10);
        rd_chk(8'h93, 8'h10);
        wr(8'h93, 8'h10);
        rd_chk(8'h93, 8'h00);
        wr(8'hab, 8'hcc);
        pulse(1'b0, 1'b0, 8'h30);
        rd_chk(8'h93, 8'h30);
        rd_chk(8'h93, 8'h00);
        chk_bit(o_int_n, 1'b1);
        wr(8'hab, 8'h5c);
        chk_bit(o_osc_run, 1'b1);
        set_data(16'h6600, 16'h0000, 8'h00);
        pulse(1'b1, 1'b0, 8'h10);
        chk_bit(o_osc_run, 1'b0);
        set_data(16'h7700, 16'h0000, 8'h00);
        pulse(1'b1, 1'b0, 8'h00);
        rd_chk(8'h95, 8'h66);
        chk_bit(o_osc_run, 1'b0);
        wr(8'h93, 8'h30);
        // Wake takes one extra cycle after the flags drop
        for (i = 0; i < 4 && o_osc_run !== 1'b1; i++) @(posedge i_ref_clk) #1;
        chk_bit(o_osc_run, 1'b1);
        if (o_osc_run !== 1'b1) finish_test();
        pulse(1'b1, 1'b0, 8'h00);
        rd_chk(8'h95, 8'h77);
        // Sleep again on a light flag, then drop the sleep bit: run resumes with flags still set
        pulse(1'b1, 1'b0, 8'h10);
        chk_bit(o_osc_run, 1'b0);
        wr(8'hab, 8'h4c);
        chk_bit(o_osc_run, 1'b1);
        @(posedge i_ref_clk);
        i_power_on_bit <= 1'b0;
        set_data(16'h8800, 16'h0000, 8'h00);
        #1;
        chk_bit(o_osc_run, 1'b0);
        pulse(1'b1, 1'b0, 8'h00);
        rd_chk(8'h95, 8'h77);
        @(posedge i_ref_clk);
        i_power_on_bit <= 1'b1;
        do_reset();
        foreach (rows[k]) rd_chk(rows[k].addr, rows[k].exp);
        finish_test();
    end
endmodule

// File: tb/reg_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side of the byte register port
// ****************************************************************
module reg_host_model (
    // Clock
    input  wire logic       i_ref_clk,
    // Register port toward the device
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    input  wire logic [7:0] i_reg_rdata
);
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
    end

    // Idle lines show the inverse, so a stale address never passes
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        o_reg_wr    <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
        #1;
    endtask

    // Read data lands at the edge that takes the strobe
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_addr <= a;
        o_reg_rd   <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~a;
        #1;
        d = i_reg_rdata;
    endtask
endmodule
